//--- cer_pkg.sv
// Shared constants and types for the circuit emulation receive adapter
package cer_pkg;
   localparam int SDU_OCTETS = 64;
   localparam int SDU_BITS   = SDU_OCTETS * 8;
   localparam int SEQ_W      = 6;
   localparam int SEQ_MOD    = 64;
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int CNT_W      = 16;
   localparam int UF_W       = 10;
   localparam int OVF_W      = 13;
   localparam logic [OVF_W-1:0] OVF_STALL_CYC = 13'h1000;
   localparam logic [BYTE_W-1:0] DUMMY_ONES  = 8'hff;
   localparam logic [BYTE_W-1:0] DUMMY_OTHER = 8'h00;
   localparam logic [5:0]        LAST_OCTET  = 6'h3f;
   localparam logic [UF_W-1:0]   UF_LAST_BIT = 10'h1ff;
   // Error reporting period
   localparam longint CLK_HZ         = 10_000_000;
   localparam longint ERR_PERIOD_S   = 900;
   localparam longint ERR_PERIOD_CYC = ERR_PERIOD_S * CLK_HZ;
   localparam int     ERR_TMR_W      = 34;

   typedef enum logic [3:0] {
      SVC_PDH_1544  = 4'h0,
      SVC_PDH_2048  = 4'h1,
      SVC_PDH_6312  = 4'h2,
      SVC_PDH_8448  = 4'h3,
      SVC_PDH_44736 = 4'h4,
      SVC_PDH_34368 = 4'h5,
      SVC_CH_64     = 4'h6,
      SVC_CH_384    = 4'h7,
      SVC_CH_1536   = 4'h8,
      SVC_CH_1920   = 4'h9,
      SVC_VOICE     = 4'ha,
      SVC_VIDEO_DTV = 4'hb
   } svc_rate_t;

   typedef struct packed {
      svc_rate_t rate;
      logic      async_xport;
   } svc_cfg_t;

   typedef struct packed {
      logic             first;
      logic             last;
      logic [SEQ_W-1:0] seq;
      logic [BYTE_W-1:0] data;
   } pdu_beat_t;

   typedef struct packed {
      logic [CNT_W-1:0] lost;
      logic [CNT_W-1:0] dup;
   } err_report_t;
endpackage

//--- sat_accum.sv
// Saturating event accumulator, cleared only by reset
`timescale 1ns/1ps
module sat_accum #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [1:0]   inc,
   output logic      [W-1:0] count
);
   logic [W-1:0] count_q;
   logic [W:0]   sum;

   assign sum   = {1'b0, count_q} + {{(W-1){1'b0}}, inc};
   assign count = count_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (sum[W]) begin
         count_q <= '1;
      end else begin
         count_q <= sum[W-1:0];
      end
   end

   chk_accum_step: assert property (@(posedge clk) disable iff (!rst_n) // see RULE16
      (inc != 2'h0 && count_q < (W'(1) << (W-1))) |=> count_q == $past(count_q) + W'($past(inc)))
      else $error("accumulator did not add its increment");
endmodule // sat_accum

//--- play_fifo.sv
// Play-out FIFO in flip-flops with valid and ready on both sides
`timescale 1ns/1ps
module play_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         wr_valid,
   output logic              wr_ready,
   input  wire logic [W-1:0] wr_data,
   output logic              rd_valid,
   input  wire logic         rd_ready,
   output logic      [W-1:0] rd_data,
   output logic              full
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [AW:0]   level_q;
   logic          do_wr;
   logic          do_rd;

   assign full     = (level_q == (AW+1)'(DEPTH));
   assign wr_ready = !full;
   assign rd_valid = (level_q != '0);
   assign rd_data  = mem_q[rptr_q];
   assign do_wr    = wr_valid && wr_ready;
   assign do_rd    = rd_valid && rd_ready;

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_q[wptr_q] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         level_q <= '0;
      end else begin
         if (do_wr) begin
            wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + AW'(1);
         end
         if (do_rd) begin
            rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + AW'(1);
         end
         level_q <= level_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   chk_fifo_level: assert property (@(posedge clk) disable iff (!rst_n)
      level_q <= (AW+1)'(DEPTH))
      else $error("fifo level above depth");
endmodule // play_fifo

//--- circuit_emulation_rx_adapter.sv
// Receive adaptation: sequence tracking, gap fill, play-out and error report
`timescale 1ns/1ps
//Contract
// (RULE1) Each service unit is exactly 64 octets and fills one protocol unit.
// (RULE2) On play-out underflow insert dummy bits so the bit count stays intact.
// (RULE3) On play-out overflow drop bits rather than shift the stream.
// (RULE4) Dummy bits for 1.544 and 2.048 Mbit/s tributaries are all ones.
// (RULE5) Detect lost frames by tracking the received frame sequence number.
// (RULE6) Frames found to be duplicates are discarded, never delivered.
// (RULE7) Insert one dummy payload per lost frame, from gaps or underflow.
// (RULE8) Dummy payload is all ones for 1.544/2.048; otherwise service dependent.
// (RULE9) Deliver service units to the tributary at constant rate from its clock.
// (RULE10) Report lost and duplicated counts through the error indication.
// (RULE11) Support 1.544 to 44.736 Mbit/s tributaries, synchronous or asynchronous.
// (RULE12) Non-locked sources use recovered clock; network-locked use network timing.
// (RULE13) Support 64, 384, 1536 and 1920 kbit/s channels with network timing.
// (RULE14) 64 kbit/s-based channels wait for the preset 8 kHz structure.
// (RULE15) Sequence numbers run 0..63 and compare modulo 64.
// (RULE16) Lost and duplicate accumulators per tributary, cleared at start-up.
// (RULE17) Period expiry raises the indication only if errors occurred; always restarts. An error in the expiry cycle is also flagged at the next expiry.
// (RULE18) Dummy payloads for a gap equal the modulo difference minus one.
module circuit_emulation_rx_adapter
   import cer_pkg::*;
#(
   parameter longint ERR_PERIOD = cer_pkg::ERR_PERIOD_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire cer_pkg::svc_cfg_t    cfg,
   input  wire logic                 structure_preset,
   input  wire logic                 pdu_valid,
   output logic                      pdu_ready,
   input  wire cer_pkg::pdu_beat_t   pdu_beat,
   input  wire logic                 rec_clk_pin,
   input  wire logic                 net_bit_tick,
   output logic                      trib_bit,
   output logic                      trib_bit_valid,
   output logic                      sequence_error_indication,
   output cer_pkg::err_report_t      err_report
);
   import cer_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_FILL = 5'b00010,
      S_PASS = 5'b00100,
      S_PAD  = 5'b01000,
      S_DROP = 5'b10000
   } rx_state_t;

   rx_state_t          state_q;
   logic               synced_q;
   logic [SEQ_W-1:0]   last_seq_q;
   logic [SEQ_W-1:0]   gap_q;
   logic [5:0]         octet_q;
   logic [SEQ_W-1:0]   seq_diff;
   logic               ones_mode;
   logic               use_rec_clk;
   logic               needs_preset;
   logic [BYTE_W-1:0]  dummy_byte;
   logic               head_ok;
   logic               dec_dup;
   logic               dec_gap;
   logic               dec_pass;
   logic               wr_valid;
   logic               wr_ready;
   logic [BYTE_W-1:0]  wr_data;
   logic               wr_fire;
   logic               unit_end;
   logic               fill_lost;

   // Service decode
   assign ones_mode    = (cfg.rate == SVC_PDH_1544) || (cfg.rate == SVC_PDH_2048); // see RULE4
   assign dummy_byte   = ones_mode ? DUMMY_ONES : DUMMY_OTHER; // see RULE8
   assign needs_preset = (cfg.rate inside {SVC_CH_64, SVC_CH_384, SVC_CH_1536, SVC_CH_1920});
   // Asynchronous PDH and distributive video run on the recovered clock
   assign use_rec_clk  = (cfg.rate == SVC_VIDEO_DTV) || // see RULE11, RULE13
                         (cfg.async_xport && (cfg.rate inside {SVC_PDH_1544, SVC_PDH_2048,
                          SVC_PDH_6312, SVC_PDH_8448, SVC_PDH_44736, SVC_PDH_34368})); // see RULE12

   // Frame head decision, compared modulo 64
   assign seq_diff = pdu_beat.seq - last_seq_q; // see RULE15
   assign head_ok  = (state_q == S_IDLE) && pdu_valid && pdu_beat.first &&
                     (!needs_preset || structure_preset); // see RULE14
   assign dec_dup  = head_ok && synced_q && (seq_diff == '0 || seq_diff[SEQ_W-1]); // see RULE6
   assign dec_gap  = head_ok && synced_q && !dec_dup && (seq_diff != 6'h01); // see RULE5
   assign dec_pass = head_ok && !dec_dup && !dec_gap;

   // FIFO write side
   assign wr_valid = ((state_q == S_PASS) && pdu_valid) ||
                     (state_q == S_FILL) || (state_q == S_PAD);
   assign wr_data  = (state_q == S_PASS) ? pdu_beat.data : dummy_byte; // see RULE8
   assign wr_fire  = wr_valid && wr_ready;
   assign unit_end = wr_fire && (octet_q == LAST_OCTET); // see RULE1
   assign fill_lost = unit_end && (state_q == S_FILL); // see RULE18

   always_comb begin
      case (state_q)
         S_IDLE:  pdu_ready = pdu_valid && !pdu_beat.first;
         S_PASS:  pdu_ready = wr_ready;
         S_DROP:  pdu_ready = 1'b1;
         default: pdu_ready = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (dec_dup) begin
                  state_q <= S_DROP;
               end else if (dec_gap) begin
                  state_q <= S_FILL;
               end else if (dec_pass) begin
                  state_q <= S_PASS;
               end
            end
            S_FILL: begin
               if (unit_end && gap_q == 6'h01) begin
                  state_q <= S_PASS;
               end
            end
            S_PASS: begin
               if (wr_fire) begin
                  if (octet_q == LAST_OCTET) begin
                     state_q <= pdu_beat.last ? S_IDLE : S_DROP; // see RULE1
                  end else if (pdu_beat.last) begin
                     state_q <= S_PAD;
                  end
               end
            end
            S_PAD: begin
               if (unit_end) begin
                  state_q <= S_IDLE;
               end
            end
            S_DROP: begin
               if (pdu_valid && pdu_beat.last) begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         synced_q   <= 1'b0;
         last_seq_q <= '0;
      end else if (dec_pass || dec_gap) begin
         synced_q   <= 1'b1;
         last_seq_q <= pdu_beat.seq; // see RULE5
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= '0;
      end else if (dec_gap) begin
         gap_q <= seq_diff - 6'h01; // see RULE18
      end else if (fill_lost) begin
         gap_q <= gap_q - 6'h01; // see RULE7
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         octet_q <= '0;
      end else if (wr_fire) begin
         octet_q <= octet_q + 6'h01;
      end
   end

   // Play-out buffer and overflow drop
   logic              rd_valid;
   logic              rd_ready;
   logic [BYTE_W-1:0] rd_data;
   logic              fifo_full;
   logic [OVF_W-1:0]  stall_q;
   logic              ovf_drop;
   logic              load;

   play_fifo #(
      .W     (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .wr_valid (wr_valid),
      .wr_ready (wr_ready),
      .wr_data  (wr_data),
      .rd_valid (rd_valid),
      .rd_ready (rd_ready),
      .rd_data  (rd_data),
      .full     (fifo_full)
   );

   // Source held off too long means the buffer has overflowed
   assign ovf_drop = (stall_q == OVF_STALL_CYC) && !load; // see RULE3
   assign rd_ready = load || ovf_drop;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stall_q <= '0;
      end else if (!(wr_valid && fifo_full) || ovf_drop) begin
         stall_q <= '0;
      end else if (stall_q != OVF_STALL_CYC) begin
         stall_q <= stall_q + OVF_W'(1);
      end
   end

   // Tributary clock from pin, two-stage synchroniser then edge detect
   logic rec_s1_q;
   logic rec_s2_q;
   logic rec_s3_q;
   logic bit_tick;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_s1_q <= 1'b0;
         rec_s2_q <= 1'b0;
         rec_s3_q <= 1'b0;
      end else begin
         rec_s1_q <= rec_clk_pin;
         rec_s2_q <= rec_s1_q;
         rec_s3_q <= rec_s2_q;
      end
   end

   assign bit_tick = use_rec_clk ? (rec_s2_q && !rec_s3_q) : net_bit_tick; // see RULE12

   // Bit serialiser
   logic [BYTE_W-1:0] shreg_q;
   logic [3:0]        bits_left_q;
   logic [UF_W-1:0]   uf_bits_q;
   logic              uf_lost;
   logic              underflow;

   assign load      = bit_tick && (bits_left_q == 4'h0) && rd_valid;
   assign underflow = bit_tick && (bits_left_q == 4'h0) && !rd_valid;
   assign uf_lost   = underflow && (uf_bits_q == UF_LAST_BIT); // see RULE7

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg_q        <= '0;
         bits_left_q    <= 4'h0;
         trib_bit       <= 1'b1;
         trib_bit_valid <= 1'b0;
      end else begin
         trib_bit_valid <= bit_tick; // see RULE9
         if (load) begin
            trib_bit    <= rd_data[BYTE_W-1];
            shreg_q     <= {rd_data[BYTE_W-2:0], 1'b0};
            bits_left_q <= 4'h7;
         end else if (underflow) begin
            trib_bit <= dummy_byte[BYTE_W-1]; // see RULE2
         end else if (bit_tick) begin
            trib_bit    <= shreg_q[BYTE_W-1];
            shreg_q     <= {shreg_q[BYTE_W-2:0], 1'b0};
            bits_left_q <= bits_left_q - 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uf_bits_q <= '0;
      end else if (load || uf_lost) begin
         uf_bits_q <= '0;
      end else if (underflow) begin
         uf_bits_q <= uf_bits_q + UF_W'(1);
      end
   end

   // Error accumulators and reporting period
   logic [1:0]           lost_inc;
   logic [1:0]           dup_inc;
   logic [CNT_W-1:0]     lost_cnt;
   logic [CNT_W-1:0]     dup_cnt;
   logic [ERR_TMR_W-1:0] tmr_q;
   logic                 seen_q;
   logic                 expire;
   logic                 any_inc;

   assign lost_inc = {1'b0, fill_lost} + {1'b0, uf_lost}; // see RULE18
   assign dup_inc  = {1'b0, dec_dup};
   assign any_inc  = (lost_inc != 2'h0) || (dup_inc != 2'h0);
   assign expire   = (tmr_q == ERR_TMR_W'(ERR_PERIOD - 1));

   sat_accum #(.W(CNT_W)) u_lost (
      .clk   (clk),
      .rst_n (rst_n),
      .inc   (lost_inc),
      .count (lost_cnt)
   );

   sat_accum #(.W(CNT_W)) u_dup (
      .clk   (clk),
      .rst_n (rst_n),
      .inc   (dup_inc),
      .count (dup_cnt)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_q <= '0;
      end else if (expire) begin
         tmr_q <= '0; // see RULE17
      end else begin
         tmr_q <= tmr_q + ERR_TMR_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else if (any_inc) begin
         seen_q <= 1'b1;
      end else if (expire) begin
         seen_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sequence_error_indication <= 1'b0;
         err_report                <= '0;
      end else begin
         sequence_error_indication <= expire && (seen_q || any_inc); // see RULE17
         if (expire && (seen_q || any_inc)) begin
            err_report.lost <= lost_cnt; // see RULE10
            err_report.dup  <= dup_cnt;
         end
      end
   end

   // Checks
   sequence s_gap_head;
      dec_gap ##1 (state_q == S_FILL);
   endsequence

   chk_dup_discard: assert property (@(posedge clk) disable iff (!rst_n) // see RULE6
      dec_dup |=> (state_q == S_DROP) && !wr_valid)
      else $error("duplicate frame not discarded");
   chk_gap_count: assert property (@(posedge clk) disable iff (!rst_n) // see RULE18
      dec_gap |=> gap_q == $past(seq_diff) - 6'h01)
      else $error("gap count wrong");
   chk_gap_fill: assert property (@(posedge clk) disable iff (!rst_n) // see RULE7
      s_gap_head |-> wr_valid && wr_data == dummy_byte)
      else $error("gap not filled with dummy payload");
   chk_unit_length: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
      unit_end |=> octet_q == 6'h00)
      else $error("service unit not 64 octets");
   chk_ones_dummy: assert property (@(posedge clk) disable iff (!rst_n) // see RULE4
      (underflow && ones_mode) |=> trib_bit && trib_bit_valid)
      else $error("underflow dummy bit not one");
   chk_fill_ones: assert property (@(posedge clk) disable iff (!rst_n) // see RULE8
      (wr_valid && state_q != S_PASS && ones_mode) |-> wr_data == 8'hff)
      else $error("dummy payload not all ones");
   chk_ovf_drop: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
      ovf_drop |-> rd_ready && rd_valid && !load)
      else $error("overflow drop did not pop buffer");
   chk_seq_track: assert property (@(posedge clk) disable iff (!rst_n) // see RULE5
      (dec_pass || dec_gap) |=> last_seq_q == $past(pdu_beat.seq) && synced_q)
      else $error("sequence number not tracked");
   chk_preset_hold: assert property (@(posedge clk) disable iff (!rst_n) // see RULE14
      (state_q == S_IDLE && needs_preset && !structure_preset) |=> state_q == S_IDLE)
      else $error("channel started without structure preset");
   chk_bit_pace: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
      trib_bit_valid |-> $past(bit_tick))
      else $error("bit delivered off the tributary tick");
   chk_quiet_period: assert property (@(posedge clk) disable iff (!rst_n) // see RULE17
      (expire && !seen_q && !any_inc) |=> !sequence_error_indication && tmr_q == '0)
      else $error("indication raised with no errors");
endmodule // circuit_emulation_rx_adapter

//--- peer_frame_source.sv
// Peer ring node model that sends adaptation frames one octet per beat
`timescale 1ns/1ps
module peer_frame_source
   import cer_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          pdu_ready,
   output logic               pdu_valid,
   output cer_pkg::pdu_beat_t pdu_beat
);
   int stalls_out;

   initial begin
      pdu_valid  = 1'b0;
      pdu_beat   = '0;
      stalls_out = 0;
   end

   // Whole unit only, head beat carries the sequence number
   task automatic send_frame(input logic [SEQ_W-1:0] seq, input logic [BYTE_W-1:0] base);
      int w;
      for (int i = 0; i < SDU_OCTETS; i++) begin
         @(negedge clk);
         pdu_valid = 1'b1;
         pdu_beat  = '{first: (i == 0), last: (i == SDU_OCTETS - 1), seq: seq,
                       data: base + i[7:0]};
         #10;
         for (w = 0; w < 6000 && pdu_ready !== 1'b1; w++) begin
            @(negedge clk);
         end
         if (w == 6000) begin
            stalls_out++;
            break;
         end
         @(posedge clk);
      end
      @(negedge clk);
      pdu_valid = 1'b0;
      // Released lines must not keep showing the last beat
      pdu_beat  = ~pdu_beat;
   endtask
endmodule // peer_frame_source

//--- circuit_emulation_rx_adapter_tb.sv
// Self-checking testbench for the circuit emulation receive adapter
`timescale 1ns/1ps
module circuit_emulation_rx_adapter_tb;
   import cer_pkg::*;
   localparam longint PERIOD = 20000;
   logic        clk;
   logic        rst_n;
   svc_cfg_t    cfg;
   logic        structure_preset;
   logic        pdu_valid;
   logic        pdu_ready;
   pdu_beat_t   pdu_beat;
   logic        net_bit_tick;
   logic        rec_clk;
   logic        rec_mode;
   logic        trib_bit;
   logic        trib_bit_valid;
   logic        sequence_error_indication;
   err_report_t err_report;
   int          fail_count;
   int          compares;

   circuit_emulation_rx_adapter #(.ERR_PERIOD(PERIOD)) u_dut (
      .clk                       (clk),
      .rst_n                     (rst_n),
      .cfg                       (cfg),
      .structure_preset          (structure_preset),
      .pdu_valid                 (pdu_valid),
      .pdu_ready                 (pdu_ready),
      .pdu_beat                  (pdu_beat),
      .rec_clk_pin               (rec_clk),
      .net_bit_tick              (net_bit_tick),
      .trib_bit                  (trib_bit),
      .trib_bit_valid            (trib_bit_valid),
      .sequence_error_indication (sequence_error_indication),
      .err_report                (err_report)
   );

   peer_frame_source u_peer (
      .clk       (clk),
      .pdu_ready (pdu_ready),
      .pdu_valid (pdu_valid),
      .pdu_beat  (pdu_beat)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check_val(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic timeout(input string what);
      fail_count++;
      $display("Error at %0t: timeout waiting for %s", $time, what);
      summarize();
   endtask

   // One tick from the selected timing source, then fetch the delivered bit
   task automatic play_bit(output logic b);
      b = 1'bx;
      @(negedge clk);
      if (rec_mode) begin
         rec_clk = 1'b1;
      end else begin
         net_bit_tick = 1'b1;
      end
      for (int i = 0; i < 6; i++) begin
         @(negedge clk);
         net_bit_tick = 1'b0;
         if (trib_bit_valid === 1'b1) begin
            b = trib_bit;
            break;
         end
      end
      rec_clk = 1'b0;
      if (b === 1'bx) begin
         timeout("bit");
      end
   endtask

   task automatic expect_octet(input logic [7:0] exp);
      logic b;
      for (int k = 7; k >= 0; k--) begin
         play_bit(b);
         check_val({15'h0, b}, {15'h0, exp[k]});
      end
   endtask

   task automatic scn_pass_frame();
      fork
         u_peer.send_frame(6'h00, 8'h10);
         begin
            repeat (100) @(negedge clk);
            for (int i = 0; i < SDU_OCTETS; i++) expect_octet(8'h10 + i[7:0]);
         end
      join
   endtask

   task automatic scn_gap();
      fork
         u_peer.send_frame(6'h03, 8'h40);
         begin
            repeat (100) @(negedge clk);
            for (int i = 0; i < 2 * SDU_OCTETS; i++) expect_octet(DUMMY_ONES);
            for (int i = 0; i < SDU_OCTETS; i++) expect_octet(8'h40 + i[7:0]);
         end
      join
   endtask

   task automatic scn_dup();
      u_peer.send_frame(6'h03, 8'h80);
      expect_octet(DUMMY_ONES);
   endtask

   // Completes a run of 512 dummy bits
   task automatic scn_underflow();
      for (int i = 0; i < SDU_OCTETS - 1; i++) expect_octet(DUMMY_ONES);
   endtask

   task automatic scn_report();
      int i;
      for (i = 0; i < 30000; i++) begin
         @(negedge clk);
         if (sequence_error_indication === 1'b1) begin
            break;
         end
      end
      if (i == 30000) begin
         timeout("error indication");
      end
      check_val(err_report.lost, 16'h0003);
      check_val(err_report.dup, 16'h0001);
      for (i = 0; i < PERIOD + 50; i++) begin
         @(negedge clk);
         check_val({15'h0, sequence_error_indication}, 16'h0000);
      end
   endtask

   // Held head, then overflow drops the oldest octet
   task automatic scn_preset();
      cfg              = '{rate: SVC_CH_64, async_xport: 1'b0};
      structure_preset = 1'b0;
      expect_octet(DUMMY_OTHER);
      fork
         u_peer.send_frame(6'h04, 8'h20);
         begin
            repeat (20) begin
               @(negedge clk);
               check_val({15'h0, pdu_ready}, 16'h0000);
            end
            structure_preset = 1'b1;
            repeat (4300) @(negedge clk);
            for (int i = 1; i < SDU_OCTETS; i++) expect_octet(8'h20 + i[7:0]);
         end
      join
   endtask

   // Asynchronous PDH paced by the recovered tributary clock pin
   task automatic scn_rec_clock();
      cfg      = '{rate: SVC_PDH_2048, async_xport: 1'b1};
      rec_mode = 1'b1;
      fork
         u_peer.send_frame(6'h05, 8'h60);
         begin
            repeat (100) @(negedge clk);
            for (int i = 0; i < SDU_OCTETS; i++) expect_octet(8'h60 + i[7:0]);
         end
      join
      expect_octet(DUMMY_ONES);
      rec_mode = 1'b0;
   endtask

   initial begin
      fail_count       = 0;
      compares         = 0;
      rst_n            = 1'b0;
      cfg              = '{rate: SVC_PDH_1544, async_xport: 1'b0};
      structure_preset = 1'b0;
      net_bit_tick     = 1'b0;
      rec_clk          = 1'b0;
      rec_mode         = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      check_val(err_report.lost, 16'h0000);
      check_val(err_report.dup, 16'h0000);
      scn_pass_frame();
      scn_gap();
      scn_dup();
      scn_underflow();
      scn_report();
      scn_preset();
      scn_rec_clock();
      check_val(u_peer.stalls_out[15:0], 16'h0000);
      summarize();
   end
endmodule // circuit_emulation_rx_adapter_tb
